/* File: pkg/gpio_pkg.sv */
package gpio_pkg;
  typedef logic [7:0] gpio_byte_type;
  localparam int NUM_PORTS = 5;
  localparam int PORT_W    = 8;
  localparam int PIN_W     = NUM_PORTS * PORT_W;
  localparam int SYNC_STAGES = 2;
  // ---------------------------------------------------------------
  // register map, port order 0,1,3,6,12
  // ---------------------------------------------------------------
  localparam logic [15:0] ADDR_LATCH [0:NUM_PORTS-1] =
    '{16'hff00, 16'hff01, 16'hff03, 16'hff06, 16'hff0c};
  localparam logic [15:0] ADDR_PULLUP [0:NUM_PORTS-1] =
    '{16'hff30, 16'hff31, 16'hff33, 16'h0000, 16'hff3c};
  localparam logic [NUM_PORTS-1:0] PULLUP_PRESENT = 5'h17;
  localparam gpio_byte_type LATCH_MASK [0:NUM_PORTS-1] =
    '{8'h03, 8'hff, 8'h0f, 8'h03, 8'h07};
  localparam gpio_byte_type PULLUP_MASK [0:NUM_PORTS-1] =
    '{8'h03, 8'hff, 8'h0f, 8'h00, 8'h01};
  localparam gpio_byte_type LATCH_RESET  = 8'h00;
  localparam gpio_byte_type PULLUP_RESET = 8'h00;
  localparam gpio_byte_type READ_NONE    = 8'h00;
  // ---------------------------------------------------------------
  // pin positions in the flat pin vectors
  // ---------------------------------------------------------------
  localparam int PIN_P00  = 0;
  localparam int PIN_P01  = 1;
  localparam int PIN_P10  = 8;
  localparam int PIN_P11  = 9;
  localparam int PIN_P12  = 10;
  localparam int PIN_P13  = 11;
  localparam int PIN_P14  = 12;
  localparam int PIN_P16  = 14;
  localparam int PIN_P17  = 15;
  localparam int PIN_P30  = 16;
  localparam int PIN_P33  = 19;
  localparam int PIN_P120 = 32;
  localparam int PIN_P121 = 33;
  localparam int PIN_P122 = 34;
  // alternate outputs that need latch 1 combine by and, the rest by or
  localparam logic [PIN_W-1:0] ALT_AND_PINS = 40'h0000000900;
  // clock pin mode select bit positions
  localparam int CLKMODE_EXT_BIT = 7;
  localparam int CLKMODE_OSC_BIT = 6;
endpackage : gpio_pkg

/* File: src/gpio_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module gpio_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  // first stage feeds only the second stage
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : gpio_sync
`default_nettype wire

/* File: src/gpio_pin_cell.sv */
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_cell #(
  parameter bit AND_MODE = 1'b0,
  parameter bit PRESENT  = 1'b1
) (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic latch_bit,
  input  wire logic dir_bit,
  input  wire logic pullup_bit,
  input  wire logic alt_en,
  input  wire logic alt_val,
  input  wire logic claimed,
  output logic      pin_out,
  output logic      pin_oe,
  output logic      pullup_on
);
  logic drive_next;
  logic oe_next;
  logic pu_next;
  // alternate output merges with the latch, so the latch idle level matters
  assign drive_next = alt_en ? (AND_MODE ? (latch_bit & alt_val)
                                         : (latch_bit | alt_val))
                             : latch_bit;
  // driver on only for direction 0, never while the oscillator owns the pin
  assign oe_next = PRESENT & ~dir_bit & ~claimed;
  // pull-up needs enable set, input mode and no alternate output
  assign pu_next = PRESENT & pullup_bit & dir_bit & ~alt_en & ~claimed;
  // registered so the pads see glitch-free levels
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      pin_out   <= 1'b0;
      pin_oe    <= 1'b0;
      pullup_on <= 1'b0;
    end
    else
    begin
      pin_out   <= drive_next & ~claimed;
      pin_oe    <= oe_next;
      pullup_on <= pu_next;
    end
  end
endmodule : gpio_pin_cell
`default_nettype wire

/* File: src/gpio_ports.sv */
`timescale 1ns/1ps
`default_nettype none
module gpio_ports (
  input  wire logic        clock,
  input  wire logic        reset,
  // cpu register access
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic        bus_bit_op,
  input  wire logic [2:0]  bus_bit_index,
  input  wire logic [7:0]  bus_wdata,
  output logic      [7:0]  bus_rdata,
  output logic             bus_rd_valid,
  // direction and clock mode from their owning registers
  input  wire logic [39:0] pin_direction_bit,
  input  wire logic [7:0]  clock_pin_mode_select_reg,
  // package pins
  input  wire logic [39:0] pin_in,
  output logic      [39:0] pin_out,
  output logic      [39:0] pin_oe,
  output logic      [39:0] pullup_connect,
  // alternate outputs from peripherals
  input  wire logic        timer0_out,
  input  wire logic        timer0_out_en,
  input  wire logic        serial_clock_pin_out,
  input  wire logic        serial_clock_pin_out_en,
  input  wire logic        serial_data_out,
  input  wire logic        serial_data_out_en,
  input  wire logic        uart_transmit_pin,
  input  wire logic        uart_transmit_pin_en,
  input  wire logic        timer_h_out,
  input  wire logic        timer_h_out_en,
  input  wire logic        timer5a_out,
  input  wire logic        timer5a_out_en,
  input  wire logic        timer5b_out,
  input  wire logic        timer5b_out_en,
  // alternate inputs to peripherals
  output logic             timer0_capture_in_a,
  output logic             timer0_capture_in_b,
  output logic             serial_clock_pin_in,
  output logic             serial_data_in,
  output logic             uart_receive_pin,
  output logic             timer5a_count_in,
  output logic             timer5b_count_in,
  output logic             ext_irq_in_zero,
  output logic      [2:0]  ext_irq_in_group,
  output logic             external_clock_in
);
  // local copies of package sizes
  localparam int NP = gpio_pkg::NUM_PORTS;
  localparam int PW = gpio_pkg::PORT_W;
  localparam int NW = gpio_pkg::PIN_W;

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // address compare, shared by latch and pull-up decode
  function automatic logic addr_match(input logic [15:0] addr,
                                      input logic [15:0] target);
    addr_match = (addr == target);
  endfunction : addr_match

  // replace one bit of a byte image, used for every single-bit write
  function automatic gpio_pkg::gpio_byte_type bit_merge(
      input gpio_pkg::gpio_byte_type image,
      input logic [2:0]              index,
      input logic                    value);
    gpio_pkg::gpio_byte_type result;
    result        = image;
    result[index] = value;
    bit_merge     = result;
  endfunction : bit_merge

  // ---------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------
  logic [NW-1:0] pin_sync;

  // every read and every alternate input sees only the second stage
  // one instance keeps a pin's read bit and tap in step
  gpio_sync #(
    .WIDTH (NW)
  ) u_pin_sync (
    .clock    (clock),
    .reset    (reset),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  // ---------------------------------------------------------------
  // oscillator pin ownership
  // ---------------------------------------------------------------
  logic          osc_sel;
  logic          ext_sel;
  logic          x1_mode;
  logic          external_clock_in_mode;
  logic [NW-1:0] claimed;

  // a mode change takes effect at the next edge
  assign osc_sel    = clock_pin_mode_select_reg[gpio_pkg::CLKMODE_OSC_BIT];
  assign ext_sel    = clock_pin_mode_select_reg[gpio_pkg::CLKMODE_EXT_BIT];
  // resonator mode takes both pins, external clock mode only the second
  assign x1_mode    = osc_sel & ~ext_sel;
  assign external_clock_in_mode = osc_sel & ext_sel;

  // a claimed pin ignores its direction and latch; selector 00 leaves plain i/o
  always_comb
  begin
    claimed                     = '0;
    claimed[gpio_pkg::PIN_P121] = x1_mode;
    claimed[gpio_pkg::PIN_P122] = osc_sel;
  end

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  logic [NP-1:0] hit_latch;
  logic [NP-1:0] hit_pullup;
  logic          wr_bit;

  // bit writes carry their value in data bit 0
  assign wr_bit = bus_wdata[0];

  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++)
    begin : g_decode
      assign hit_latch[gp]  = addr_match(bus_addr, gpio_pkg::ADDR_LATCH[gp]);
      // a port without pull-ups has no pull-up address at all
      assign hit_pullup[gp] = gpio_pkg::PULLUP_PRESENT[gp] &
                              addr_match(bus_addr, gpio_pkg::ADDR_PULLUP[gp]);
    end
  endgenerate

  // ---------------------------------------------------------------
  // per-port latches and pull-up enables
  // ---------------------------------------------------------------
  gpio_pkg::gpio_byte_type latch_reg   [0:NP-1];
  gpio_pkg::gpio_byte_type latch_next  [0:NP-1];
  gpio_pkg::gpio_byte_type pullup_reg  [0:NP-1];
  gpio_pkg::gpio_byte_type pullup_next [0:NP-1];

  // views and write images
  gpio_pkg::gpio_byte_type rd_view     [0:NP-1];
  gpio_pkg::gpio_byte_type latch_wval  [0:NP-1];
  gpio_pkg::gpio_byte_type pullup_wval [0:NP-1];
  gpio_pkg::gpio_byte_type dir_view    [0:NP-1];
  gpio_pkg::gpio_byte_type sync_view   [0:NP-1];
  gpio_pkg::gpio_byte_type claim_view  [0:NP-1];

  generate
    for (gp = 0; gp < NP; gp++)
    begin : g_port
      assign dir_view[gp]   = pin_direction_bit[gp*PW +: PW];
      assign sync_view[gp]  = pin_sync[gp*PW +: PW];
      assign claim_view[gp] = claimed[gp*PW +: PW];

      // read image: input bits show the pin, output bits show the latch;
      // any modify sequence by the cpu starts from this same image;
      // the pin half lags the pad by two edges
      assign rd_view[gp] = gpio_pkg::LATCH_MASK[gp] & ~claim_view[gp] &
                           ((dir_view[gp] & sync_view[gp]) |
                            (~dir_view[gp] & latch_reg[gp]));

      // a bit write rewrites the whole port from the read image, so an
      // input pin's latch picks up its pin level as a side effect
      assign latch_wval[gp] = gpio_pkg::LATCH_MASK[gp] &
                              (bus_bit_op ?
                               bit_merge(rd_view[gp], bus_bit_index, wr_bit) :
                               bus_wdata);

      // pull-up register has no pin side, so its image is the stored value
      assign pullup_wval[gp] = gpio_pkg::PULLUP_MASK[gp] &
                               (bus_bit_op ?
                                bit_merge(pullup_reg[gp], bus_bit_index, wr_bit) :
                                bus_wdata);

      // only a write loads; reads leave the latch alone
      assign latch_next[gp] = (bus_wr & hit_latch[gp]) ? latch_wval[gp]
                                                       : latch_reg[gp];
      assign pullup_next[gp] = (bus_wr & hit_pullup[gp]) ? pullup_wval[gp]
                                                         : pullup_reg[gp];

      // both registers clear on reset
      always_ff @(posedge clock)
      begin
        if (reset)
        begin
          latch_reg[gp]  <= gpio_pkg::LATCH_RESET;
          pullup_reg[gp] <= gpio_pkg::PULLUP_RESET;
        end
        else
        begin
          latch_reg[gp]  <= latch_next[gp];
          pullup_reg[gp] <= pullup_next[gp];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // read data path
  // ---------------------------------------------------------------
  gpio_pkg::gpio_byte_type rd_chain [0:NP];
  gpio_pkg::gpio_byte_type rd_mux;

  assign rd_chain[0] = gpio_pkg::READ_NONE;

  // or-chain of the selected images; an unmapped address reads zero
  // addresses are unique, so no priority is needed
  generate
    for (gp = 0; gp < NP; gp++)
    begin : g_rd
      assign rd_chain[gp+1] = rd_chain[gp] |
                              ({PW{hit_latch[gp]}}  & rd_view[gp]) |
                              ({PW{hit_pullup[gp]}} & pullup_reg[gp]);
    end
  endgenerate

  assign rd_mux = rd_chain[NP];

  // one-cycle read latency; rdata holds until the next read
  // valid answers every strobe, mapped or not
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      bus_rdata    <= gpio_pkg::READ_NONE;
      bus_rd_valid <= 1'b0;
    end
    else
    begin
      bus_rd_valid <= bus_rd;
      if (bus_rd)
      begin
        bus_rdata <= rd_mux;
      end
    end
  end

  // ---------------------------------------------------------------
  // alternate output routing
  // ---------------------------------------------------------------
  logic [NW-1:0] alt_en;
  logic [NW-1:0] alt_val;

  // peripherals only merge; software must set direction and latch level
  always_comb
  begin
    alt_en                      = '0;
    alt_val                     = '0;

    // port0 source
    alt_en[gpio_pkg::PIN_P01]   = timer0_out_en;
    alt_val[gpio_pkg::PIN_P01]  = timer0_out;

    // port1 sources
    alt_en[gpio_pkg::PIN_P10]   = serial_clock_pin_out_en;
    alt_val[gpio_pkg::PIN_P10]  = serial_clock_pin_out;
    alt_en[gpio_pkg::PIN_P12]   = serial_data_out_en;
    alt_val[gpio_pkg::PIN_P12]  = serial_data_out;
    alt_en[gpio_pkg::PIN_P13]   = uart_transmit_pin_en;
    alt_val[gpio_pkg::PIN_P13]  = uart_transmit_pin;
    alt_en[gpio_pkg::PIN_P16]   = timer_h_out_en;
    alt_val[gpio_pkg::PIN_P16]  = timer_h_out;
    alt_en[gpio_pkg::PIN_P17]   = timer5a_out_en;
    alt_val[gpio_pkg::PIN_P17]  = timer5a_out;

    // port3 source
    alt_en[gpio_pkg::PIN_P33]   = timer5b_out_en;
    alt_val[gpio_pkg::PIN_P33]  = timer5b_out;
  end

  // ---------------------------------------------------------------
  // pin cells
  // ---------------------------------------------------------------
  logic [NW-1:0] latch_flat;
  logic [NW-1:0] pullup_flat;

  // flatten the port arrays, one bit per cell
  genvar gb;
  generate
    for (gp = 0; gp < NP; gp++)
    begin : g_flat
      assign latch_flat[gp*PW +: PW]  = latch_reg[gp];
      assign pullup_flat[gp*PW +: PW] = pullup_reg[gp];
    end

    // absent bits get a cell with driver and pull-up held off
    for (gb = 0; gb < NW; gb++)
    begin : g_cell
      gpio_pin_cell #(
        .AND_MODE (gpio_pkg::ALT_AND_PINS[gb]),
        .PRESENT  (gpio_pkg::LATCH_MASK[gb/PW][gb%PW])
      ) u_cell (
        .clock      (clock),
        .reset      (reset),
        .latch_bit  (latch_flat[gb]),
        .dir_bit    (pin_direction_bit[gb]),
        .pullup_bit (pullup_flat[gb]),
        .alt_en     (alt_en[gb]),
        .alt_val    (alt_val[gb]),
        .claimed    (claimed[gb]),
        .pin_out    (pin_out[gb]),
        .pin_oe     (pin_oe[gb]),
        .pullup_on  (pullup_connect[gb])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // alternate input taps
  // ---------------------------------------------------------------
  // taps are always live; the peripheral works only with direction input
  assign timer0_capture_in_a = pin_sync[gpio_pkg::PIN_P00];
  assign timer0_capture_in_b = pin_sync[gpio_pkg::PIN_P01];
  assign serial_clock_pin_in = pin_sync[gpio_pkg::PIN_P10];
  assign serial_data_in      = pin_sync[gpio_pkg::PIN_P11];
  assign uart_receive_pin    = pin_sync[gpio_pkg::PIN_P14];
  assign timer5a_count_in    = pin_sync[gpio_pkg::PIN_P17];
  assign timer5b_count_in    = pin_sync[gpio_pkg::PIN_P33];

  // interrupt inputs, group in pin order
  assign ext_irq_in_zero     = pin_sync[gpio_pkg::PIN_P120];
  assign ext_irq_in_group    = pin_sync[gpio_pkg::PIN_P30 +: 3];

  // external clock tap passes only in its mode; limited to well below
  // half the system clock because it is sampled, not a true clock path
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      external_clock_in <= 1'b0;
    end
    else
    begin
      external_clock_in <= external_clock_in_mode & pin_sync[gpio_pkg::PIN_P122];
    end
  end
endmodule : gpio_ports
`default_nettype wire

/* File: bench/gpio_board.sv */
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// board side of the package pins
// ---------------------------------------------------------------
module gpio_board (
  input  wire logic        clock,
  input  wire logic [39:0] pin_out,
  input  wire logic [39:0] pin_oe,
  input  wire logic [39:0] pullup_connect,
  input  wire logic [39:0] drv_en,
  input  wire logic [39:0] drv_val,
  output logic      [39:0] pin_in
);
  logic [39:0] float_pat;
  // a floating pin keeps changing so a stale level never reads as valid
  always_ff @(posedge clock)
  begin
    float_pat <= (float_pat === 40'h5555555555) ? 40'haaaaaaaaaa : 40'h5555555555;
  end
  // chip driver wins, then board, then pull-up to high
  assign pin_in = (pin_oe & pin_out)
                | (~pin_oe & drv_en & drv_val)
                | (~pin_oe & ~drv_en & (pullup_connect | float_pat));
endmodule : gpio_board
`default_nettype wire

/* File: bench/gpio_ports_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// port behaviour checker
// ---------------------------------------------------------------
module gpio_ports_chk (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic [15:0] bus_addr,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic        bus_bit_op,
  input wire logic [7:0]  bus_wdata,
  input wire logic [7:0]  bus_rdata,
  input wire logic        bus_rd_valid,
  input wire logic [39:0] pin_direction_bit,
  input wire logic [7:0]  clock_pin_mode_select_reg,
  input wire logic [39:0] pin_in,
  input wire logic [39:0] pin_out,
  input wire logic [39:0] pin_oe,
  input wire logic [39:0] pullup_connect
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // read answer comes exactly one cycle later, never unasked
  chk_rd_valid_pulse: assert property (bus_rd |=> bus_rd_valid)
    else $error("read valid missing");
  chk_no_spare_valid: assert property (!bus_rd |=> !bus_rd_valid)
    else $error("read valid without read");
  // held reset leaves every pad quiet
  chk_reset_quiet: assert property (disable iff (1'b0) reset ##1 reset |->
    pin_oe == 40'h0 && pullup_connect == 40'h0 && !bus_rd_valid)
    else $error("outputs not cleared in reset");
  // port1 has no claimed pins, so its driver follows direction only
  chk_oe_follows_dir: assert property (!$past(reset) |->
    pin_oe[15:8] == ~$past(pin_direction_bit[15:8]))
    else $error("port1 driver enable wrong");
  chk_no_pullup_out: assert property (!$past(reset) |->
    (pullup_connect & ~$past(pin_direction_bit)) == 40'h0)
    else $error("pull-up on output pin");
  // bits 1,4,5 of port1 have no alternate output, so the latch shows
  chk_latch_to_pin: assert property (bus_wr && !bus_bit_op && bus_addr == 16'hff01
    ##1 !(bus_wr && bus_addr == 16'hff01) |=>
    (pin_out[15:8] & 8'h32) == ($past(bus_wdata, 2) & 8'h32))
    else $error("port1 pin not driven from latch");
  chk_read_latch: assert property (bus_rd && bus_addr == 16'hff01
    && pin_direction_bit[15:8] == 8'h00 && !$past(bus_wr) |=>
    (bus_rdata & 8'h32) == ($past(pin_out[15:8]) & 8'h32))
    else $error("output mode read not latch");
  chk_read_pin: assert property (bus_rd && bus_addr == 16'hff01
    && pin_direction_bit[15:8] == 8'hff && !$past(reset) && !$past(reset, 2)
    && $stable(pin_in[15:8]) && $past(pin_in[15:8], 2) == pin_in[15:8] |=>
    bus_rdata == $past(pin_in[15:8]))
    else $error("input mode read not pin level");
  chk_unmapped_zero: assert property (bus_rd && (bus_addr == 16'hff02
    || bus_addr == 16'hff36) |=> bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_claimed_pins: assert property (clock_pin_mode_select_reg[7:6] == 2'b01
    && $past(clock_pin_mode_select_reg[7:6]) == 2'b01 |->
    pin_oe[34:33] == 2'b00 && pullup_connect[34:33] == 2'b00)
    else $error("oscillator pins still driven");
endmodule : gpio_ports_chk
bind gpio_ports gpio_ports_chk u_chk (.clock(clock), .reset(reset), .bus_addr(bus_addr),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_bit_op(bus_bit_op), .bus_wdata(bus_wdata),
  .bus_rdata(bus_rdata), .bus_rd_valid(bus_rd_valid), .pin_in(pin_in),
  .pin_direction_bit(pin_direction_bit), .pin_out(pin_out), .pin_oe(pin_oe),
  .clock_pin_mode_select_reg(clock_pin_mode_select_reg), .pullup_connect(pullup_connect));
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct { logic [15:0] addr; logic [7:0] wdata; logic [7:0] rexp; } gpio_row_type;
  logic        clock, reset, bus_wr, bus_rd, bus_bit_op, bus_rd_valid;
  logic [15:0] bus_addr;
  logic [2:0]  bus_bit_index;
  logic [7:0]  bus_wdata, bus_rdata, mode, rd_data;
  logic [39:0] dir, pin_in, pin_out, pin_oe, pullup_connect, drv_en, drv_val;
  logic        t0, t0_en, sck, sck_en, tx_en, urx, xclk;
  wire  [9:0]  taps;
  wire  [9:0]  tap_pins = {pin_in[18:16], pin_in[32], pin_in[19], pin_in[15],
                           pin_in[9:8], pin_in[1:0]};
  int          fail_count, compares;
  int          cycles = 0;
  gpio_row_type rows [11];
  // ---------------------------------------------------------------
  // clock, design and board
  // ---------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  gpio_ports dut (.clock(clock), .reset(reset), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_bit_op(bus_bit_op), .bus_bit_index(bus_bit_index),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rd_valid(bus_rd_valid),
    .pin_direction_bit(dir), .clock_pin_mode_select_reg(mode), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pullup_connect(pullup_connect),
    .timer0_out(t0), .timer0_out_en(t0_en), .serial_clock_pin_out(sck),
    .serial_clock_pin_out_en(sck_en), .serial_data_out(t0), .serial_data_out_en(t0_en),
    .uart_transmit_pin(1'b0), .uart_transmit_pin_en(tx_en), .timer_h_out(t0),
    .timer_h_out_en(t0_en), .timer5a_out(sck), .timer5a_out_en(sck_en),
    .timer5b_out(t0), .timer5b_out_en(t0_en), .timer0_capture_in_a(taps[0]),
    .timer0_capture_in_b(taps[1]), .serial_clock_pin_in(taps[2]), .serial_data_in(taps[3]),
    .uart_receive_pin(urx), .timer5a_count_in(taps[4]), .timer5b_count_in(taps[5]),
    .ext_irq_in_zero(taps[6]), .ext_irq_in_group(taps[9:7]), .external_clock_in(xclk));
  gpio_board u_board (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_connect(pullup_connect), .drv_en(drv_en), .drv_val(drv_val), .pin_in(pin_in));
  // ---------------------------------------------------------------
  // bus tasks and checks
  // ---------------------------------------------------------------
  task automatic stop_test();
    if (fail_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic check(input string name, input logic [39:0] exp, input logic [39:0] got);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : idle
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic bit_op,
                    input logic [2:0] idx);
    @(posedge clock);
    bus_addr <= a;
    bus_wdata <= d;
    bus_bit_op <= bit_op;
    bus_bit_index <= idx;
    bus_wr <= 1'b1;
    @(posedge clock);
    bus_wr <= 1'b0;
  endtask : wr
  // the answer stands from one edge after the strobe
  task automatic rd(input logic [15:0] a);
    @(posedge clock);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clock);
    bus_rd <= 1'b0;
    #1;
    rd_data = bus_rdata;
    check("rd_valid", 40'h1, {39'h0, bus_rd_valid});
  endtask : rd
  // timeout guard; a run needs under a thousand cycles
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      fail_count++;
      stop_test();
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    {bus_wr, bus_rd, bus_bit_op, bus_bit_index, bus_addr, bus_wdata} = '0;
    {t0, t0_en, sck, sck_en, tx_en, mode, drv_en, drv_val} = '0;
    {fail_count, compares} = '0;
    reset = 1'b1;
    dir = 40'hffffffffff;
    rows = '{'{16'hff00, 8'hff, 8'h03}, '{16'hff01, 8'ha5, 8'ha5},
             '{16'hff03, 8'hff, 8'h0f}, '{16'hff06, 8'hff, 8'h03},
             '{16'hff0c, 8'hff, 8'h07}, '{16'hff30, 8'hff, 8'h03},
             '{16'hff31, 8'h5a, 8'h5a}, '{16'hff33, 8'hff, 8'h0f},
             '{16'hff3c, 8'hff, 8'h01}, '{16'hff36, 8'hff, 8'h00},
             '{16'hff02, 8'hff, 8'h00}};
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    dir <= 40'h0;
    idle(3);
    check("oe_reset", 40'h07030fff03, pin_oe);
    foreach (rows[i])
    begin
      rd(rows[i].addr);
      check("reset_value", 40'h0, {32'h0, rd_data});
    end
    // byte write then read back, unimplemented bits and places read zero
    foreach (rows[i])
    begin
      wr(rows[i].addr, rows[i].wdata, 1'b0, 3'h0);
      rd(rows[i].addr);
      check("byte_rw", {32'h0, rows[i].rexp}, {32'h0, rd_data});
    end
    check("pin_out_p1", 40'ha5, {32'h0, pin_out[15:8]});
    // pull-up only on input pins without an alternate output
    @(posedge clock) dir[15:8] <= 8'hff;
    idle(3);
    check("pullup_in", 40'h5a, {32'h0, pullup_connect[15:8]});
    @(posedge clock) dir[15:8] <= 8'h0f;
    idle(3);
    check("pullup_mix", 40'h0a, {32'h0, pullup_connect[15:8]});
    @(posedge clock) {dir[15:8], tx_en} <= {8'hff, 1'b1};
    idle(3);
    check("pullup_alt", 40'h52, {32'h0, pullup_connect[15:8]});
    // input-mode write lands in the latch only
    @(posedge clock) {tx_en, drv_en[15:8], drv_val[15:8]} <= {1'b0, 8'hff, 8'h3c};
    wr(16'hff01, 8'hc3, 1'b0, 3'h0);
    idle(3);
    check("oe_input", 40'h0, {32'h0, pin_oe[15:8]});
    rd(16'hff01);
    check("read_pin", 40'h3c, {32'h0, rd_data});
    @(posedge clock) dir[15:8] <= 8'h00;
    idle(3);
    rd(16'hff01);
    check("latch_kept", 40'hc3, {32'h0, rd_data});
    check("pin_drive", 40'hc3, {32'h0, pin_out[15:8]});
    // bit write on a mixed port rewrites the whole byte from the read image
    @(posedge clock) {dir[15:8], drv_val[15:8]} <= {8'hf0, 8'ha0};
    idle(3);
    wr(16'hff01, 8'h00, 1'b1, 3'h0);
    @(posedge clock) dir[15:8] <= 8'h00;
    idle(3);
    rd(16'hff01);
    check("bit_mixed", 40'ha2, {32'h0, rd_data});
    wr(16'hff03, 8'h00, 1'b1, 3'h2);
    rd(16'hff03);
    check("bit_output", 40'h0b, {32'h0, rd_data});
    // oscillator modes claim the clock pins
    @(posedge clock) {mode, drv_en[34], drv_val[34]} <= {8'h40, 2'b11};
    idle(3);
    check("osc_oe", 40'h1, {37'h0, pin_oe[34:32]});
    rd(16'hff0c);
    check("osc_read", 40'h01, {32'h0, rd_data});
    @(posedge clock) mode <= 8'hc0;
    idle(4);
    check("ext_clk", 40'h1, {39'h0, xclk});
    rd(16'hff0c);
    check("ext_read", 40'h03, {32'h0, rd_data});
    @(posedge clock) mode <= 8'h00;
    rd(16'hff0c);
    check("io_read", 40'h07, {32'h0, rd_data});
    // alternate outputs with the latch set as software must
    wr(16'hff00, 8'h00, 1'b0, 3'h0);
    wr(16'hff01, 8'h01, 1'b0, 3'h0);
    @(posedge clock) {t0_en, t0, sck_en, sck} <= 4'b1110;
    idle(3);
    check("alt_or", 40'h1, {39'h0, pin_out[1]});
    check("alt_and", 40'h0, {39'h0, pin_out[8]});
    @(posedge clock) {t0, sck} <= 2'b01;
    idle(3);
    check("alt_or0", 40'h0, {39'h0, pin_out[1]});
    check("alt_and1", 40'h1, {39'h0, pin_out[8]});
    // alternate input taps, on an input pin and on the driven output pins
    @(posedge clock) {dir[12], drv_en[12], drv_val[12]} <= 3'b111;
    idle(4);
    check("rx_tap", 40'h1, {39'h0, urx});
    check("alt_taps", {30'h0, tap_pins}, {30'h0, taps});
    // a second reset in mid-run clears the port1 pull-up enables again
    @(posedge clock) reset <= 1'b1;
    idle(2);
    @(posedge clock) reset <= 1'b0;
    rd(16'hff31);
    check("reset_again", 40'h0, {32'h0, rd_data});
    stop_test();
  end
endmodule : tb
`default_nettype wire
